/* File: inc/cascade_router_defines.vh */
// constants for the cascade serial word router
// assumes words are 16 bits, frame sync one bit clock ahead of msb
`ifndef CASCADE_ROUTER_DEFINES_VH
`define CASCADE_ROUTER_DEFINES_VH
`define WORD_BITS        16
`define CNT_BITS         4
`define CTRL_FLAG_BIT    15
`define READ_BIT         14
`define ADDR_MSB         13
`define ADDR_LSB         11
`define REG_MSB          10
`define REG_LSB          8
`define DATA_MSB         7
`define REG_A            3'h0
`define REG_B            3'h1
`define REG_C            3'h2
`define A_DATA_BIT       0
`define A_MIXED_BIT      1
`define A_COUNT_MSB      4
`define A_COUNT_LSB      2
`define A_RESET          8'h00
`define B_RESET          8'h00
`define C_RESET          8'h00
`endif

/* File: logic/codec_cascade_serial_router.v */
// serial word router for one codec in a daisy chain
// assumes bit clock is ref_clk_i; all inputs synchronous to it
`timescale 1ns/1ps
`include "cascade_router_defines.vh"
module codec_cascade_serial_router #(
  parameter MAX_DEVICES = 8
) (
  input  wire                    ref_clk_i,
  input  wire                    rst_i,
  input  wire                    sample_event_i,
  input  wire [`WORD_BITS-1:0]   sample_word_i,
  input  wire                    input_frame_sync_i,
  input  wire                    serial_data_in_i,
  output reg                     output_frame_sync_o,
  output reg                     serial_data_out_o,
  output reg  [`WORD_BITS-1:0]   dac_word_o,
  output reg                     dac_load_o,
  output reg  [7:0]              control_register_a_o,
  output reg  [7:0]              control_register_b_o,
  output reg  [7:0]              control_register_c_o,
  output wire                    program_data_select_o,
  output wire                    mixed_mode_select_o,
  output wire                    analog_power_up_o,
  output reg                     sample_valid_o
);

////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'h0;
localparam ST_RECV = 2'h1;

reg  [1:0]            state_reg;
reg  [3:0]            bit_cnt_reg;
reg  [`WORD_BITS-1:0] shift_in_reg;
reg  [`WORD_BITS-1:0] shift_out_reg;
reg  [3:0]            out_cnt_reg;
reg                   out_busy_reg;
reg  [`CNT_BITS-1:0]  frame_cnt_reg;
reg                   fire_reg;
reg  [`WORD_BITS-1:0] fire_word_reg;

assign program_data_select_o = control_register_a_o[`A_DATA_BIT];
assign mixed_mode_select_o   = control_register_a_o[`A_MIXED_BIT] &
                               control_register_a_o[`A_DATA_BIT];
assign analog_power_up_o     = control_register_c_o[0];

wire [`CNT_BITS-1:0] dev_count = {1'b0, control_register_a_o[`A_COUNT_MSB:`A_COUNT_LSB]};
wire [`WORD_BITS-1:0] rx_word  = {shift_in_reg[`WORD_BITS-2:0], serial_data_in_i};
wire [2:0] rx_addr = rx_word[`ADDR_MSB:`ADDR_LSB];
wire [2:0] rx_reg  = rx_word[`REG_MSB:`REG_LSB];
wire rx_ctrl_flag  = rx_word[`CTRL_FLAG_BIT];
wire data_mode     = program_data_select_o & ~mixed_mode_select_o;
wire word_done     = (state_reg == ST_RECV) && (bit_cnt_reg == 4'hf);
// in mixed mode the msb picks control versus dac
wire is_dac_word   = data_mode | (mixed_mode_select_o & ~rx_ctrl_flag);
wire is_ctrl_word  = ~program_data_select_o |
                     (mixed_mode_select_o & rx_ctrl_flag);
// count of 0 treated as single device
wire [`CNT_BITS-1:0] cnt_target = (dev_count == {`CNT_BITS{1'b0}}) ?
                                  {{(`CNT_BITS-1){1'b0}}, 1'b1} : dev_count;
wire [`CNT_BITS-1:0] cnt_plus   = frame_cnt_reg + {{(`CNT_BITS-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////
// receive shifter: sync one clock ahead of msb
always @(posedge ref_clk_i) begin
  if (rst_i) begin
    state_reg    <= ST_IDLE;
    bit_cnt_reg  <= 4'h0;
    shift_in_reg <= {`WORD_BITS{1'b0}};
  end else begin
    case (state_reg)
      ST_IDLE: begin
        if (input_frame_sync_i) begin
          state_reg   <= ST_RECV;
          bit_cnt_reg <= 4'h0;
        end
      end
      ST_RECV: begin
        shift_in_reg <= rx_word;
        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == 4'hf) begin
          state_reg <= input_frame_sync_i ? ST_RECV : ST_IDLE;
        end
      end
      default: begin
        state_reg <= ST_IDLE;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// word decode: control writes, reads, dac counting
always @(posedge ref_clk_i) begin
  if (rst_i) begin
    control_register_a_o <= `A_RESET;
    control_register_b_o <= `B_RESET;
    control_register_c_o <= `C_RESET;
    dac_word_o           <= {`WORD_BITS{1'b0}};
    dac_load_o           <= 1'b0;
    frame_cnt_reg        <= {`CNT_BITS{1'b0}};
    fire_reg             <= 1'b0;
    fire_word_reg        <= {`WORD_BITS{1'b0}};
  end else begin
    dac_load_o <= 1'b0;
    fire_reg   <= 1'b0;
    if (word_done) begin
      if (is_dac_word) begin
        if (cnt_plus == cnt_target) begin
          dac_word_o    <= rx_word;
          dac_load_o    <= 1'b1;
          frame_cnt_reg <= {`CNT_BITS{1'b0}};
        end else begin
          frame_cnt_reg <= cnt_plus;
          fire_reg      <= 1'b1;
          // the word just received is the one passed down the chain
          fire_word_reg <= rx_word;
        end
      end else if (is_ctrl_word && rx_ctrl_flag && rx_addr != 3'h0) begin
        fire_reg      <= 1'b1;
        fire_word_reg <= {rx_word[15:14], rx_addr - 3'h1, rx_word[10:0]};
      end else if (is_ctrl_word && rx_ctrl_flag) begin
        if (rx_word[`READ_BIT]) begin
          fire_reg      <= 1'b1;
          fire_word_reg <= {rx_word[15:8],
            (rx_reg == `REG_A) ? control_register_a_o :
            (rx_reg == `REG_B) ? control_register_b_o :
            (rx_reg == `REG_C) ? control_register_c_o : 8'h00};
        end else begin
          case (rx_reg)
            `REG_A: control_register_a_o <= rx_word[`DATA_MSB:0];
            `REG_B: control_register_b_o <= rx_word[`DATA_MSB:0];
            `REG_C: control_register_c_o <= rx_word[`DATA_MSB:0];
            default: begin
            end
          endcase
        end
      end else begin
        fire_reg      <= 1'b1;
        fire_word_reg <= rx_word;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// transmit: sample event fires sync on all devices together
always @(posedge ref_clk_i) begin
  if (rst_i) begin
    output_frame_sync_o <= 1'b0;
    serial_data_out_o   <= 1'b0;
    shift_out_reg       <= {`WORD_BITS{1'b0}};
    out_cnt_reg         <= 4'h0;
    out_busy_reg        <= 1'b0;
    sample_valid_o      <= 1'b0;
  end else begin
    output_frame_sync_o <= 1'b0;
    if (sample_event_i) begin
      // fresh sample; valid only in data or mixed mode
      shift_out_reg       <= sample_word_i;
      sample_valid_o      <= program_data_select_o;
      output_frame_sync_o <= 1'b1;
      out_busy_reg        <= 1'b1;
      out_cnt_reg         <= 4'h0;
    end else if (fire_reg) begin
      // sync feeds next device input sync
      shift_out_reg       <= fire_word_reg;
      output_frame_sync_o <= 1'b1;
      out_busy_reg        <= 1'b1;
      out_cnt_reg         <= 4'h0;
      sample_valid_o      <= 1'b0;
    end else if (out_busy_reg) begin
      serial_data_out_o <= shift_out_reg[`WORD_BITS-1];
      shift_out_reg     <= {shift_out_reg[`WORD_BITS-2:0], 1'b0};
      out_cnt_reg       <= out_cnt_reg + 4'h1;
      if (out_cnt_reg == 4'hf) begin
        out_busy_reg <= 1'b0;
      end
    end
  end
end

endmodule

/* File: dv/router_checker.sv */
// port assertions for the cascade router
// assumes it is bound to codec_cascade_serial_router
`timescale 1ns/1ps
`include "cascade_router_defines.vh"
module router_checker (
  input wire       ref_clk_i,
  input wire       rst_i,
  input wire       sample_event_i,
  input wire       input_frame_sync_i,
  input wire       output_frame_sync_o,
  input wire       dac_load_o,
  input wire [7:0] control_register_a_o,
  input wire [7:0] control_register_b_o,
  input wire [7:0] control_register_c_o,
  input wire       program_data_select_o,
  input wire       mixed_mode_select_o,
  input wire       analog_power_up_o
);
  reg [4:0] ss_reg;
  reg [4:0] se_reg;
  // saturating ages, so a stale cause never looks fresh
  always @(posedge ref_clk_i) begin
    ss_reg <= rst_i ? 5'h1f : input_frame_sync_i ? 5'h00 : ss_reg + {4'h0, ss_reg != 5'h1f};
    se_reg <= rst_i ? 5'h1f : sample_event_i ? 5'h00 : se_reg + {4'h0, se_reg != 5'h1f};
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_sync_single: assert property (output_frame_sync_o |=> !output_frame_sync_o)
    else $error("output sync too long");
  a_power_bit: assert property (analog_power_up_o == control_register_c_o[0])
    else $error("power bit wrong");
  a_select_bit: assert property (program_data_select_o == control_register_a_o[`A_DATA_BIT])
    else $error("select bit wrong");
  a_mixed_both: assert property (mixed_mode_select_o ==
    (control_register_a_o[`A_MIXED_BIT] & control_register_a_o[`A_DATA_BIT])) else $error("mixed");
  a_dac_mode: assert property (dac_load_o |-> program_data_select_o)
    else $error("dac load in program mode");
  a_dac_cause: assert property (dac_load_o |-> ss_reg <= 5'h16)
    else $error("dac load without word");
  a_reg_cause: assert property (!$stable({control_register_a_o, control_register_b_o,
    control_register_c_o}) |-> ss_reg <= 5'h16) else $error("register write without word");
  a_out_cause: assert property ($rose(output_frame_sync_o) |->
    ss_reg <= 5'h16 || se_reg <= 5'h06) else $error("output sync without cause");
endmodule
bind codec_cascade_serial_router router_checker checker_inst (.ref_clk_i, .rst_i,
  .sample_event_i, .input_frame_sync_i, .output_frame_sync_o, .dac_load_o,
  .control_register_a_o, .control_register_b_o, .control_register_c_o,
  .program_data_select_o, .mixed_mode_select_o, .analog_power_up_o);

/* File: dv/host_port_model.sv */
// host serial port model on the router's serial pins
// assumes one bit clock; drives on falling edges
`timescale 1ns/1ps
module host_port_model (
  input  wire        ref_clk_i,
  input  wire        output_frame_sync_i,
  input  wire        serial_data_out_i,
  output reg         frame_sync_o = 1'b0,
  output reg         data_o = 1'b0,
  output reg  [15:0] rx_word_o,
  output reg         rx_done_o = 1'b0
);
  integer n = 16;
  task send(input [15:0] w);
    integer i;
    begin
      @(negedge ref_clk_i);
      frame_sync_o = 1'b1;
      for (i = 15; i >= 0; i = i - 1) begin
        @(negedge ref_clk_i);
        frame_sync_o = 1'b0;
        data_o = w[i];
      end
      // released line inverts, a stale bit never reads right
      @(negedge ref_clk_i);
      data_o = ~w[0];
    end
  endtask
  always @(posedge ref_clk_i) begin
    rx_done_o <= 1'b0;
    if (output_frame_sync_i === 1'b1) n <= 0;
    else if (n < 16) begin
      rx_word_o <= {rx_word_o[14:0], serial_data_out_i};
      n <= n + 1;
      rx_done_o <= (n == 15);
    end
  end
endmodule

/* File: dv/codec_cascade_serial_router_tb.sv */
// random and corner stimulus for one router
// assumes the host model sits on the serial pins
`timescale 1ns/1ps
`include "cascade_router_defines.vh"
module codec_cascade_serial_router_tb;
  reg         ref_clk_i = 0, rst_i = 1, sample_event_i = 0;
  reg  [15:0] sample_word_i = 0, w, e;
  wire        ifs, sdi, ofs, serial_data_out, h_done, dac_load_o, sel, mix, pwr, vld;
  wire [15:0] h_word, dac_word_o;
  wire [7:0]  reg_a, reg_b, reg_c;
  integer     miscompares = 0, comparisons = 0, seed = 66963, loads = 0, i, k;
  initial forever #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (dac_load_o === 1'b1) loads = loads + 1;
  codec_cascade_serial_router dut (.ref_clk_i, .rst_i, .sample_event_i, .sample_word_i,
    .input_frame_sync_i(ifs), .serial_data_in_i(sdi), .output_frame_sync_o(ofs),
    .serial_data_out_o(serial_data_out), .dac_word_o, .dac_load_o, .control_register_a_o(reg_a),
    .control_register_b_o(reg_b), .control_register_c_o(reg_c), .program_data_select_o(sel),
    .mixed_mode_select_o(mix), .analog_power_up_o(pwr), .sample_valid_o(vld));
  host_port_model host (.ref_clk_i, .output_frame_sync_i(ofs), .serial_data_out_i(serial_data_out),
    .frame_sync_o(ifs), .data_o(sdi), .rx_word_o(h_word), .rx_done_o(h_done));
  task chk(input [15:0] s, input [15:0] x, input [31:0] n);
    begin
      comparisons = comparisons + 1;
      if (s !== x) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", n, x, s);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task idle; repeat (4) @(negedge ref_clk_i); endtask
  task get; for (k = 0; k < 80 && h_done !== 1'b1; k = k + 1) @(posedge ref_clk_i) #1; endtask
  task rst12; begin rst_i = 1; repeat (12) @(negedge ref_clk_i); rst_i = 0; end endtask
  task evt(input [15:0] s);
    begin
      @(negedge ref_clk_i);
      {sample_event_i, sample_word_i} = {1'b1, s};
      @(negedge ref_clk_i);
      sample_event_i = 0;
      get;
    end
  endtask
  function [15:0] cw(input rd, input [2:0] rg, input [7:0] d);
    cw = {1'b1, rd, 3'h0, rg, d};
  endfunction
  initial begin
    rst12;
    chk(reg_a, `A_RESET, "ra");
    evt(16'h5a5a);
    chk(h_done, 1, "evt");
    chk(vld, 0, "vld");
    for (i = 0; i < 14; i = i + 1) begin
      w = $random(seed);
      w[15] = i[0];
      if (i[0]) w[13:11] = i[3:1] + 3'h1;
      e = w;
      if (i[0]) e[13:11] = w[13:11] - 3'h1;
      repeat (w[1:0]) @(negedge ref_clk_i);
      host.send(w);
      get;
      chk(h_word, e, "fwd");
    end
    host.send(cw(0, `REG_C, 8'h01));
    host.send(cw(0, `REG_B, w[7:0]));
    idle;
    chk(pwr, 1, "pwr");
    chk(reg_b, w[7:0], "rb");
    host.send(cw(1, `REG_C, 8'h00));
    get;
    chk(h_word[7:0], 8'h01, "rdc");
    host.send(cw(0, `REG_A, 8'h09));
    idle;
    chk(sel, 1, "sel");
    evt(e);
    chk(h_word, e, "adc");
    chk(vld, 1, "vld");
    for (i = 0; i < 4; i = i + 1) begin
      w = $random(seed);
      host.send(w);
      if (!i[0]) get;
      else idle;
      chk(i[0] ? dac_word_o : h_word, w, "dac");
      chk(loads, (i + 1) / 2, "ld");
    end
    rst12;
    host.send(cw(0, `REG_A, 8'h07));
    idle;
    chk(mix, 1, "mix");
    host.send(cw(1, `REG_A, 8'h00));
    get;
    chk(h_word[7:0], 8'h07, "rda");
    w = $random(seed) & 16'h7fff;
    host.send(w);
    idle;
    chk(dac_word_o, w, "mdac");
    chk(loads, 3, "ld");
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule
